// >>> hw/cic_pkg.sv
// Shared constants and types for the core interrupt controller.
// Assumes a single 200 MHz clock and four clock phases per instruction cycle.
package cic_pkg;

  // ==========================================================================
  // Register map, byte offsets on the plain register port
  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_PEN1     = 4'h1;
  localparam logic [3:0] OFS_OPTION   = 4'h2;
  localparam logic [3:0] OFS_PFLAGS   = 4'h3;

  // ==========================================================================
  // Field positions
  localparam int GEN_BIT   = 7;
  localparam int PGATE_BIT = 6;
  localparam int T0IE_BIT  = 5;
  localparam int PINEN_BIT = 4;
  localparam int PCHEN_BIT = 3;
  localparam int T0IF_BIT  = 2;
  localparam int PINFL_BIT = 1;
  localparam int PCHFL_BIT = 0;
  localparam int EDGE_BIT  = 6;
  localparam int STATUS_TMOUT_BIT = 4;
  localparam int STATUS_PWRDN_BIT = 3;

  // ==========================================================================
  // Reset values and fixed figures
  localparam logic [7:0]  RST_CTRL   = 8'h00;
  localparam logic [7:0]  RST_PEN1   = 8'h00;
  localparam logic [7:0]  RST_OPTION = 8'h00;
  localparam logic [14:0] VECTOR_ADDR = 15'h0004;
  // Peripheral sources able to run without the system clock
  localparam logic [7:0]  PERIPH_WAKE_MASK = 8'h60;
  localparam int PHASES_PER_CYCLE = 4;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } cic_phase_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_FLUSH = 3'b010,
    ST_CALL  = 3'b100
  } cic_state_t;

  typedef struct packed {
    logic [7:0]  w;
    logic [7:0]  status;
    logic [4:0]  bank_sel;
    logic [15:0] ind_ptr0;
    logic [15:0] ind_ptr1;
    logic [6:0]  pc_high;
  } cic_ctx_t;

  typedef struct packed {
    logic flush;
    logic push_pc;
    logic vector_load;
    logic restore;
    logic wake;
  } cic_core_cmd_t;

endpackage

// >>> hw/cic_core_irq.sv
// Interrupt controller of the 8-bit core: flags, enables, entry sequence,
// wake from sleep and shadow context.
// Assumes the core sequencer and peripherals share clk; only the external
// pin is asynchronous.
`timescale 1ns/100ps

module cic_core_irq
  import cic_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Register port
  input  wire logic [3:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [7:0]         reg_rdata,
  // Event sources
  input  wire logic          ext_irq_pin,
  input  wire logic          timer0_rollover,
  input  wire logic          pin_change_any,
  input  wire logic [7:0]    periph_flags,
  // Core sequencer
  input  wire logic          core_sleeping,
  input  wire logic          core_return,
  input  wire cic_ctx_t      core_ctx,
  output cic_core_cmd_t      core_cmd,
  output logic [14:0]        vector_addr,
  output cic_ctx_t           restore_ctx,
  output logic               global_irq_enable_out
);

  // ==========================================================================
  // Request combination shared by vectoring and wake
  function automatic logic irq_request(
    input logic [7:0] ctl,
    input logic [7:0] pen,
    input logic [7:0] pfl
  );
    logic core_req;
    logic per_req;
    core_req = (ctl[T0IE_BIT] & ctl[T0IF_BIT]) |
               (ctl[PINEN_BIT] & ctl[PINFL_BIT]) |
               (ctl[PCHEN_BIT] & ctl[PCHFL_BIT]);
    per_req  = ctl[PGATE_BIT] & (|(pen & pfl));
    return core_req | per_req;
  endfunction

  // ==========================================================================
  // State
  cic_phase_t phase;
  cic_state_t state;
  logic       global_irq_enable;
  logic       peripheral_gate_enable;
  logic       timer0_overflow_enable;
  logic       ext_pin_irq_enable;
  logic       pin_change_enable;
  logic       timer0_overflow_flag;
  logic       ext_pin_irq_flag;
  logic       pin_change_flag;
  logic       ext_edge_select;
  logic [7:0] peripheral_irq_enable_1;
  logic       pin_meta;
  logic       pin_sync;
  logic       pin_prev;
  logic       edge_seen;
  logic       sleep_prev;
  logic [7:0] snap_ctl;
  logic [7:0] snap_pen;
  logic       wake_skip;
  cic_ctx_t   shadow;

  logic [7:0] ctrl_view;
  logic       is_q1;
  logic       flag_window;
  logic       pin_edge;
  logic       take_irq;
  logic       enter_call;
  logic       wake_now;
  logic       wr_ctrl;

  assign ctrl_view   = {global_irq_enable, peripheral_gate_enable, timer0_overflow_enable,
                        ext_pin_irq_enable, pin_change_enable, timer0_overflow_flag,
                        ext_pin_irq_flag, pin_change_flag};
  assign is_q1       = (phase == PH_Q1);
  assign flag_window = (phase == PH_Q4) || (phase == PH_Q1);
  assign wr_ctrl     = reg_wr && (reg_addr == OFS_CTRL);
  // Selected edge of the synchronised pin
  assign pin_edge    = ext_edge_select ? (pin_sync & ~pin_prev)
                                       : (~pin_sync & pin_prev);
  // Sampled only at Q1 and never in the cycle right after a wake
  assign take_irq    = is_q1 && (state == ST_RUN) && global_irq_enable && !core_sleeping &&
                       !wake_skip && irq_request(ctrl_view, peripheral_irq_enable_1,
                                                 periph_flags);
  assign enter_call  = is_q1 && (state == ST_FLUSH);
  // Wake needs enables held at sleep entry and still held now
  assign wake_now    = core_sleeping && sleep_prev &&
                       irq_request(ctrl_view & snap_ctl, peripheral_irq_enable_1 & snap_pen,
                                   periph_flags);

  // ==========================================================================
  // Instruction clock phases
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase <= PH_Q1;
    end else begin
      unique case (phase)
        PH_Q1: phase <= PH_Q2;
        PH_Q2: phase <= PH_Q3;
        PH_Q3: phase <= PH_Q4;
        PH_Q4: phase <= PH_Q1;
        default: phase <= PH_Q1;
      endcase
    end
  end

  // ==========================================================================
  // External pin synchroniser and edge capture
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= ext_irq_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Edge held until the flag window opens
  always_ff @(posedge clk) begin
    if (!nrst) begin
      edge_seen <= 1'b0;
    end else if (flag_window) begin
      edge_seen <= 1'b0;
    end else if (pin_edge) begin
      edge_seen <= 1'b1;
    end
  end

  // ==========================================================================
  // Control register: enables
  always_ff @(posedge clk) begin
    if (!nrst) begin
      peripheral_gate_enable <= RST_CTRL[PGATE_BIT];
      timer0_overflow_enable <= RST_CTRL[T0IE_BIT];
      ext_pin_irq_enable     <= RST_CTRL[PINEN_BIT];
      pin_change_enable      <= RST_CTRL[PCHEN_BIT];
    end else if (wr_ctrl) begin
      peripheral_gate_enable <= reg_wdata[PGATE_BIT];
      timer0_overflow_enable <= reg_wdata[T0IE_BIT];
      ext_pin_irq_enable     <= reg_wdata[PINEN_BIT];
      pin_change_enable      <= reg_wdata[PCHEN_BIT];
    end
  end

  // Global enable: entry clears, return sets, both above software
  always_ff @(posedge clk) begin
    if (!nrst) begin
      global_irq_enable <= RST_CTRL[GEN_BIT];
    end else if (enter_call) begin
      global_irq_enable <= 1'b0;
    end else if (core_return) begin
      global_irq_enable <= 1'b1;
    end else if (wr_ctrl) begin
      global_irq_enable <= reg_wdata[GEN_BIT];
    end
  end

  // ==========================================================================
  // Flags: a hardware set beats a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      timer0_overflow_flag <= RST_CTRL[T0IF_BIT];
    end else if (timer0_rollover) begin
      timer0_overflow_flag <= 1'b1;
    end else if (wr_ctrl) begin
      timer0_overflow_flag <= reg_wdata[T0IF_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_pin_irq_flag <= RST_CTRL[PINFL_BIT];
    end else if (flag_window && (edge_seen || pin_edge)) begin
      ext_pin_irq_flag <= 1'b1;
    end else if (wr_ctrl) begin
      ext_pin_irq_flag <= reg_wdata[PINFL_BIT];
    end
  end

  // Pin-change flag mirrors the source; writes cannot touch it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_change_flag <= RST_CTRL[PCHFL_BIT];
    end else begin
      pin_change_flag <= pin_change_any;
    end
  end

  // ==========================================================================
  // Peripheral enables and edge select
  always_ff @(posedge clk) begin
    if (!nrst) begin
      peripheral_irq_enable_1 <= RST_PEN1;
    end else if (reg_wr && (reg_addr == OFS_PEN1)) begin
      peripheral_irq_enable_1 <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_edge_select <= RST_OPTION[EDGE_BIT];
    end else if (reg_wr && (reg_addr == OFS_OPTION)) begin
      ext_edge_select <= reg_wdata[EDGE_BIT];
    end
  end

  // ==========================================================================
  // Read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL:   reg_rdata <= ctrl_view;
        OFS_PEN1:   reg_rdata <= peripheral_irq_enable_1;
        OFS_OPTION: reg_rdata <= {1'b0, ext_edge_select, 6'h00};
        OFS_PFLAGS: reg_rdata <= periph_flags;
        default:    reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // Sleep tracking and wake
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sleep_prev <= 1'b0;
      snap_ctl   <= 8'h00;
      snap_pen   <= 8'h00;
    end else begin
      sleep_prev <= core_sleeping;
      if (core_sleeping && !sleep_prev) begin
        // Timer0 runs from the system clock, so it cannot wake
        snap_ctl <= {1'b0, ctrl_view[PGATE_BIT], 1'b0, ctrl_view[PINEN_BIT],
                     ctrl_view[PCHEN_BIT], 3'h7};
        snap_pen <= peripheral_irq_enable_1 & PERIPH_WAKE_MASK;
      end
    end
  end

  // Blocks exactly one Q1 sample after leaving sleep
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wake_skip <= 1'b0;
    end else if (core_sleeping) begin
      wake_skip <= 1'b1;
    end else if (is_q1) begin
      wake_skip <= 1'b0;
    end
  end

  // ==========================================================================
  // Entry sequence, stepped only at Q1 so a 2-cycle instruction
  // in flight is cut by the flush instead of stretching latency
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= ST_RUN;
    end else begin
      unique case (state)
        ST_RUN: begin
          if (take_irq) begin
            state <= ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          if (is_q1) begin
            state <= ST_CALL;
          end
        end
        ST_CALL: begin
          if (is_q1) begin
            state <= ST_RUN;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // Command pulses to the core, one clock each except wake, which stays high while the wake request holds in sleep
  always_ff @(posedge clk) begin
    if (!nrst) begin
      core_cmd <= '0;
    end else begin
      core_cmd.flush       <= take_irq;
      core_cmd.push_pc     <= enter_call;
      core_cmd.vector_load <= is_q1 && (state == ST_CALL);
      core_cmd.restore     <= core_return;
      core_cmd.wake        <= wake_now;
    end
  end

  // ==========================================================================
  // Shadow context
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shadow <= '0;
    end else if (enter_call) begin
      shadow <= core_ctx;
      // Core keeps its own timeout and power-down bits
      shadow.status[STATUS_TMOUT_BIT] <= 1'b0;
      shadow.status[STATUS_PWRDN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      restore_ctx <= '0;
    end else if (core_return) begin
      restore_ctx <= shadow;
    end
  end

  // ==========================================================================
  // Registered outputs: fixed vector and a copy of the global enable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      vector_addr           <= VECTOR_ADDR;
      global_irq_enable_out <= 1'b0;
    end else begin
      vector_addr           <= VECTOR_ADDR;
      global_irq_enable_out <= global_irq_enable;
    end
  end

endmodule

// >>> testbench/cic_core_model.sv
// Model of the core sequencer as seen by the interrupt controller.
// Assumes the controller's command pulses and a bench request to return.
`timescale 1ns/100ps
module cic_core_model
  import cic_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Controller side
  input  wire cic_core_cmd_t core_cmd,
  input  wire cic_ctx_t      restore_ctx,
  input  wire logic          ret_req,
  output cic_ctx_t           core_ctx,
  output logic               core_return
);
  logic in_isr;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      in_isr   <= 1'b0;
      core_ctx <= 60'h0123_4567_89ab_cd0;
    end else begin
      if (core_cmd.vector_load) begin
        in_isr <= 1'b1;
      end
      if (core_return) begin
        in_isr <= 1'b0;
      end
      // Routine scribbles on context so a lost restore shows
      if (in_isr) begin
        core_ctx <= core_ctx + 60'h1;
      end
      if (core_cmd.restore) begin
        core_ctx <= restore_ctx;
      end
    end
  end

  // Return only from inside a routine
  assign core_return = ret_req & in_isr;
endmodule

// >>> testbench/cic_core_irq_sva.sv
// Assertion checker for the core interrupt controller.
// Assumes it is bound onto cic_core_irq and sees only its ports.
`timescale 1ns/100ps
module cic_core_irq_sva
  import cic_pkg::*;
(
  // Clock and reset
  input wire logic          clk,
  input wire logic          nrst,
  // Register port
  input wire logic [3:0]    reg_addr,
  input wire logic [7:0]    reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [7:0]    reg_rdata,
  // Event sources
  input wire logic          ext_irq_pin,
  input wire logic          timer0_rollover,
  input wire logic          pin_change_any,
  input wire logic [7:0]    periph_flags,
  // Core sequencer
  input wire logic          core_sleeping,
  input wire logic          core_return,
  input wire cic_ctx_t      core_ctx,
  input wire cic_core_cmd_t core_cmd,
  input wire logic [14:0]   vector_addr,
  input wire cic_ctx_t      restore_ctx,
  input wire logic          global_irq_enable_out
);
  // ========
  // Entry and return sequence, fixed vector and sleep wake
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_flush_push;
    core_cmd.flush |-> ##4 core_cmd.push_pc ##1 (!core_cmd.push_pc)[*3];
  endproperty
  a_flush_push: assert property (p_flush_push) else $error("push late");
  property p_push_vec;
    core_cmd.push_pc |-> ##4 core_cmd.vector_load;
  endproperty
  a_push_vec: assert property (p_push_vec) else $error("vector late");
  property p_gie_clear;
    core_cmd.push_pc |-> ##2 !global_irq_enable_out;
  endproperty
  a_gie_clear: assert property (p_gie_clear) else $error("enable kept");
  property p_flush_gie;
    core_cmd.flush |-> global_irq_enable_out;
  endproperty
  a_flush_gie: assert property (p_flush_gie) else $error("taken while off");
  property p_restore;
    core_return |=> core_cmd.restore;
  endproperty
  a_restore: assert property (p_restore) else $error("no restore");
  property p_ret_gie;
    core_return |-> ##3 global_irq_enable_out;
  endproperty
  a_ret_gie: assert property (p_ret_gie) else $error("enable not set");
  property p_vec_const;
    vector_addr == VECTOR_ADDR;
  endproperty
  a_vec_const: assert property (p_vec_const) else $error("bad vector");
  property p_sleep_wake;
    core_cmd.wake |-> $past(core_sleeping) && !core_cmd.flush;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("wake awake");

  c_take: cover property (core_cmd.flush);
  c_restore: cover property (core_cmd.restore);
  c_wake: cover property (core_cmd.wake);
endmodule

// >>> testbench/cic_core_irq_tb.sv
// Self-checking bench for the core interrupt controller.
// Assumes cic_pkg, the core model and the checker are compiled first.
`timescale 1ns/100ps
module cic_core_irq_tb;
  import cic_pkg::*;
  logic          clk, nrst, reg_wr, reg_rd, ret_req;
  logic          ext_irq_pin, timer0_rollover, pin_change_any;
  logic          core_sleeping, core_return, global_irq_enable_out;
  logic [3:0]    reg_addr;
  logic [7:0]    reg_wdata, reg_rdata, periph_flags;
  logic [14:0]   vector_addr;
  cic_ctx_t      core_ctx, restore_ctx, snap;
  cic_core_cmd_t core_cmd;
  int            err_total, check_count, cyc, n;

  cic_core_irq dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin), .timer0_rollover(timer0_rollover),
    .pin_change_any(pin_change_any), .periph_flags(periph_flags), .core_sleeping(core_sleeping),
    .core_return(core_return), .core_ctx(core_ctx), .core_cmd(core_cmd), .vector_addr(vector_addr),
    .restore_ctx(restore_ctx), .global_irq_enable_out(global_irq_enable_out));
  cic_core_model u_core (.clk(clk), .nrst(nrst), .core_cmd(core_cmd), .restore_ctx(restore_ctx),
    .ret_req(ret_req), .core_ctx(core_ctx), .core_return(core_return));

  // ========
  // Helpers; all driving happens 1 ns after an edge
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    step(1);
    reg_wr    <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    step(1);
    reg_rd   <= 1'b0;
    chk(64'(reg_rdata), 64'(exp));
  endtask
  task automatic wait_bit(input int b, input int lim);
    n = 0;
    while (core_cmd[b] !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
  endtask
  task automatic leave_isr;
    ret_req <= 1'b1;
    step(1);
    ret_req <= 1'b0;
    step(3);
  endtask

  // ========
  // Scenarios
  task automatic t_regs;
    rchk(4'h0, 8'h00);
    rchk(4'h1, 8'h00);
    rchk(4'h9, 8'h00);
    wr(4'h0, 8'h7f);
    rchk(4'h0, 8'h7e);
    for (int i = 0; i < 8; i++) begin
      wr(4'h1, 8'h01 << i);
      rchk(4'h1, 8'h01 << i);
    end
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h00);
    $display("Register test done");
  endtask
  task automatic t_flags;
    timer0_rollover <= 1'b1;
    step(1);
    timer0_rollover <= 1'b0;
    rchk(4'h0, 8'h04);
    step(8);
    rchk(4'h0, 8'h04);
    wr(4'h0, 8'h00);
    pin_change_any <= 1'b1;
    step(2);
    rchk(4'h0, 8'h01);
    pin_change_any <= 1'b0;
    step(2);
    rchk(4'h0, 8'h00);
    $display("Flag test done");
  endtask
  task automatic t_timer;
    wr(4'h0, 8'ha0);
    timer0_rollover <= 1'b1;
    step(1);
    timer0_rollover <= 1'b0;
    wait_bit(2, 20);
    chk(64'(n >= 8 && n <= 13), 64'h1);
    snap = core_ctx;
    rchk(4'h0, 8'h24);
    wr(4'h0, 8'h20);
    leave_isr;
    chk(64'(core_ctx), 64'(snap));
    rchk(4'h0, 8'ha0);
    wr(4'h0, 8'h00);
    $display("Timer entry test done");
  endtask
  task automatic t_pin;
    for (int e = 0; e < 2; e++) begin
      wr(4'h2, e[0] ? 8'h40 : 8'h00);
      rchk(4'h2, e[0] ? 8'h40 : 8'h00);
      ext_irq_pin <= e[0];
      step(8);
      wr(4'h0, 8'h00);
      ext_irq_pin <= ~e[0];
      step(8);
      rchk(4'h0, 8'h00);
      ext_irq_pin <= e[0];
      step(8);
      rchk(4'h0, 8'h02);
    end
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h90);
    ext_irq_pin <= 1'b0;
    step(8);
    ext_irq_pin <= 1'b1;
    wait_bit(2, 30);
    chk(64'(n >= 8 && n <= 22), 64'h1);
    rchk(4'h0, 8'h12);
    wr(4'h0, 8'h10);
    leave_isr;
    rchk(4'h0, 8'h90);
    wr(4'h0, 8'h00);
    $display("Pin test done");
  endtask
  task automatic t_gate;
    wr(4'h1, 8'h01);
    periph_flags <= 8'h01;
    wr(4'h0, 8'h40);
    rchk(4'h3, 8'h01);
    wait_bit(4, 16);
    chk(64'(n), 64'd16);
    wr(4'h0, 8'h80);
    wait_bit(4, 16);
    chk(64'(n), 64'd16);
    wr(4'h0, 8'hc0);
    wait_bit(4, 16);
    chk(64'(n < 16), 64'h1);
    wait_bit(2, 16);
    periph_flags <= 8'h00;
    leave_isr;
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h00);
    $display("Peripheral gate test done");
  endtask
  task automatic t_sleep;
    wr(4'h1, 8'h41);
    wr(4'h0, 8'h40);
    core_sleeping <= 1'b1;
    periph_flags  <= 8'h01;
    wait_bit(0, 12);
    chk(64'(n), 64'd12);
    periph_flags <= 8'h40;
    wait_bit(0, 12);
    chk(64'(n < 12), 64'h1);
    core_sleeping <= 1'b0;
    wait_bit(4, 12);
    chk(64'(n), 64'd12);
    periph_flags <= 8'h00;
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h00);
    $display("Sleep test done");
  endtask

  // ========
  // Verdict, clock, watchdog and main sequence
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Whole run is well under 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      give_verdict;
    end
  end

  initial begin
    {nrst, reg_wr, reg_rd, ret_req, ext_irq_pin, timer0_rollover} = 6'h0;
    {pin_change_any, core_sleeping} = 2'h0;
    reg_addr     = 4'h0;
    reg_wdata    = 8'h00;
    periph_flags = 8'h00;
    step(10);
    nrst <= 1'b1;
    step(1);
    t_regs;
    t_flags;
    t_timer;
    t_pin;
    t_gate;
    t_sleep;
    give_verdict;
  end
endmodule

bind cic_core_irq cic_core_irq_sva u_sva (.*);
